// *** rtl/host_bus_device.sv ***
// device end: register access over the host pins
`timescale 1ns/1ns
`default_nettype none
// How it works
// - separate strobes: read drives addressed register
// - separate strobes: write loads addressed register
// - strobe mode: data strobe times each access
// - strobe mode: direction line held through strobe
// - chip select low gates every access
// - hard init low keeps reset state
// - host keeps clock running during init
// - data lines released while in reset
// - width pin picks 8 or 16 bits
// - A0 with lane select picks byte lane
// - separate strobes: select marks upper lane
// - strobe mode: select marks lower lane
// - 8-bit mode ignores lane select
// - protocol pin picks strobe style
// - one combined maskable interrupt output
// - summary plus six group status registers
// - pin style register sets irq drive
// - unused half released on byte transfers
// - muxed address latched on ale fall
// - 8-bit mode keeps upper lines released
module host_bus_device #(
    parameter int MEM_BYTES = 1024,
    parameter int GROUPS    = host_bus_pkg::IRQ_GROUPS
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    // pins
    host_bus_if.device               bus,
    // user side
    input  wire logic [GROUPS*8-1:0] irqEvents,
    output logic                     writeSeen,
    output logic      [9:0]          writeAddr
);
    localparam int GW = GROUPS * 8;
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] mask_reg [GROUPS];
    logic [1:0] ipc_reg;
    logic [9:0] latchAddr_reg;
    logic       ale_reg;
    logic       rdPrev_reg;
    logic       wrPrev_reg;
    logic [1:0] accLanes_reg;
    logic [9:0] accLo_reg;
    logic [9:0] accHi_reg;
    logic [15:0] accData_reg;
    logic [15:0] devData_reg;
    logic [15:0] devOe_reg;
    logic        writeSeen_reg;
    logic [9:0]  writeAddr_reg;
    wire         inReset;
    wire         wide;
    wire         moto;
    wire  [9:0]  effAddr;
    wire         selected;
    wire         rdAct;
    wire         wrAct;
    wire  [1:0]  lanes;
    wire         swap;
    wire  [9:0]  loAddr;
    wire  [9:0]  hiAddr;
    wire         commit;
    wire         rdEnd;
    logic [GW-1:0] maskFlat;
    logic [GW-1:0] clearVec;
    logic [GW-1:0] status;
    logic [7:0]    summary;

    // lane enables {upper, lower} for one access
    function automatic logic [1:0] laneDecode(input logic w, input logic m,
                                              input logic a0, input logic selN);
        if (!w)
            laneDecode = 2'h1;
        else if (!a0 && !selN)
            laneDecode = 2'h3;
        else if (a0 && selN)
            laneDecode = 2'h0;
        else if (m)
            laneDecode = selN ? 2'h2 : 2'h1;
        else
            laneDecode = selN ? 2'h1 : 2'h2;
    endfunction

    // byte as seen by the host at one address
    function automatic logic [7:0] byteAt(input logic [9:0] a);
        byteAt = mem[a];
        for (int g = 0; g < GROUPS; g++)
        begin
            if (a == host_bus_pkg::MASK_BASE + 10'(g))
                byteAt = mask_reg[g];
            if (a == host_bus_pkg::STAT_BASE + 10'(g))
                byteAt = status[g*8 +: 8];
        end
        if (a == host_bus_pkg::GIS_ADDR)
            byteAt = summary;
        if (a == host_bus_pkg::IPC_ADDR)
            byteAt = {6'h00, ipc_reg};
    endfunction

    // static mode pins and access decode
    assign inReset  = !bus.hardInitN;
    assign wide     = bus.busWidthSel;
    assign moto     = bus.hostProtocolSel;
    assign effAddr  = bus.muxBusSel ? latchAddr_reg : bus.addr;
    assign selected = !bus.csN && !inReset;
    assign rdAct    = selected && !bus.rdDsN && (!moto || bus.wrRwN);
    assign wrAct    = selected && !rdAct && (moto ? !bus.rdDsN : !bus.wrRwN);
    assign lanes    = laneDecode(wide, moto, effAddr[0], bus.byteLaneSelN);
    // in strobe mode the even byte rides the upper lane
    assign swap     = moto;
    assign loAddr   = wide ? {effAddr[9:1], swap} : effAddr;
    assign hiAddr   = {effAddr[9:1], !swap};
    assign commit   = wrPrev_reg && !wrAct;
    assign rdEnd    = rdPrev_reg && !rdAct;

    // clear-on-read of status bytes at the end of a read
    always_comb
    begin
        clearVec = '0;
        maskFlat = '0;
        for (int g = 0; g < GROUPS; g++)
        begin
            maskFlat[g*8 +: 8] = mask_reg[g];
            if (rdEnd && accLanes_reg[0] && accLo_reg == host_bus_pkg::STAT_BASE + 10'(g))
                clearVec[g*8 +: 8] = 8'hff;
            if (rdEnd && accLanes_reg[1] && accHi_reg == host_bus_pkg::STAT_BASE + 10'(g))
                clearVec[g*8 +: 8] = 8'hff;
        end
    end

    // multiplexed address capture
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ale_reg       <= 1'b0;
            latchAddr_reg <= '0;
        end
        else
        begin
            ale_reg <= bus.ale;
            if (ale_reg && !bus.ale)
                latchAddr_reg <= bus.addr;
        end
    end

    // access tracking, reloaded every cycle while a strobe is active, held after it ends
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdPrev_reg   <= 1'b0;
            wrPrev_reg   <= 1'b0;
            accLanes_reg <= '0;
            accLo_reg    <= '0;
            accHi_reg    <= '0;
            accData_reg  <= '0;
        end
        else
        begin
            rdPrev_reg <= rdAct;
            wrPrev_reg <= wrAct;
            if (rdAct || wrAct)
            begin
                accLanes_reg <= lanes;
                accLo_reg    <= loAddr;
                accHi_reg    <= hiAddr;
                accData_reg  <= bus.dataLine;
            end
        end
    end

    // register writes commit when the write strobe ends
    always_ff @(posedge core_clk)
    begin
        for (int l = 0; l < 2; l++)
            if (commit && accLanes_reg[l])
                mem[l == 1 ? accHi_reg : accLo_reg] <= accData_reg[l*8 +: 8];
    end

    // control registers with defined reset values
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ipc_reg <= host_bus_pkg::IPC_OPEN_DRAIN;
            for (int g = 0; g < GROUPS; g++)
                mask_reg[g] <= host_bus_pkg::MASK_RESET;
        end
        else if (inReset)
        begin
            ipc_reg <= host_bus_pkg::IPC_OPEN_DRAIN;
            for (int g = 0; g < GROUPS; g++)
                mask_reg[g] <= host_bus_pkg::MASK_RESET;
        end
        else if (commit)
        begin
            for (int l = 0; l < 2; l++)
            begin
                if (accLanes_reg[l] && (l == 1 ? accHi_reg : accLo_reg) == host_bus_pkg::IPC_ADDR)
                    ipc_reg <= accData_reg[l*8 +: 2];
                for (int g = 0; g < GROUPS; g++)
                    if (accLanes_reg[l] &&
                        (l == 1 ? accHi_reg : accLo_reg) == host_bus_pkg::MASK_BASE + 10'(g))
                        mask_reg[g] <= accData_reg[l*8 +: 8];
            end
        end
    end

    // data drivers: only enabled lanes, only while reading
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            devData_reg <= '0;
            devOe_reg   <= '0;
        end
        else if (rdAct)
        begin
            devData_reg <= {byteAt(hiAddr), byteAt(loAddr)};
            devOe_reg   <= {{8{lanes[1]}}, {8{lanes[0]}}};
        end
        else
        begin
            devData_reg <= '0;
            devOe_reg   <= '0;
        end
    end

    // user notice of each completed write
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            writeSeen_reg <= 1'b0;
            writeAddr_reg <= '0;
        end
        else
        begin
            writeSeen_reg <= commit && (accLanes_reg != 2'h0);
            if (commit)
                writeAddr_reg <= accLanes_reg[0] ? accLo_reg : accHi_reg;
        end
    end

    irq_unit #(
        .GROUPS   (GROUPS)
    ) irqBlock (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .initN    (bus.hardInitN),
        .events   (irqEvents),
        .clear    (clearVec),
        .mask     (maskFlat),
        .pinStyle (ipc_reg),
        .status   (status),
        .summary  (summary),
        .irqOut   (bus.irqOut),
        .irqOe    (bus.irqOe)
    );

    assign bus.devData = devData_reg;
    assign bus.devOe   = devOe_reg;
    assign writeSeen   = writeSeen_reg;
    assign writeAddr   = writeAddr_reg;
endmodule
`default_nettype wire

// *** pkg/host_bus_pkg.sv ***
// shared constants for the host bus port and its controller
package host_bus_pkg;
    localparam int ADDR_W     = 10;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int IRQ_GROUPS = 6;
    // device register map, byte addresses
    localparam logic [9:0] MASK_BASE = 10'h3e0;
    localparam logic [9:0] STAT_BASE = 10'h3e8;
    localparam logic [9:0] GIS_ADDR  = 10'h3ee;
    localparam logic [9:0] IPC_ADDR  = 10'h3ef;
    localparam logic [7:0] MASK_RESET = 8'hff;
    // irq pin styles
    localparam logic [1:0] IPC_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] IPC_PP_LOW     = 2'h1;
    localparam logic [1:0] IPC_PP_HIGH    = 2'h2;
    // controller registers on apb
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] ADDR_OFS  = 8'h04;
    localparam logic [7:0] WDATA_OFS = 8'h08;
    localparam logic [7:0] RDATA_OFS = 8'h0c;
    localparam logic [7:0] STAT_OFS  = 8'h10;
    localparam int CTRL_GO   = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_WORD = 2;
    localparam int CTRL_WIDE = 4;
    localparam int CTRL_MOTO = 5;
    localparam int CTRL_MUX  = 6;
    localparam int CTRL_INIT = 7;
    localparam int STAT_BUSY = 0;
    localparam int STAT_IRQ  = 1;
    localparam int STROBE_CYCLES = 4;
endpackage

// *** pkg/host_bus_if.sv ***
// pin bundle between host controller and device port
`timescale 1ns/1ns
`default_nettype none
interface host_bus_if;
    logic [9:0]  addr;
    logic        csN;
    logic        rdDsN;
    logic        wrRwN;
    logic        byteLaneSelN;
    logic        ale;
    logic        busWidthSel;
    logic        hostProtocolSel;
    logic        muxBusSel;
    logic        hardInitN;
    logic [15:0] hostData;
    logic [15:0] hostOe;
    logic [15:0] devData;
    logic [15:0] devOe;
    logic        irqOut;
    logic        irqOe;
    logic [15:0] dataLine;
    logic        irqLine;
    // resolved wire levels, undriven lines pulled high
    always_comb
    begin
        for (int i = 0; i < 16; i++)
            dataLine[i] = devOe[i] ? devData[i] : (hostOe[i] ? hostData[i] : 1'b1);
        irqLine = irqOe ? irqOut : 1'b1;
    end
    modport device (input addr, csN, rdDsN, wrRwN, byteLaneSelN, ale, busWidthSel,
                    hostProtocolSel, muxBusSel, hardInitN, dataLine,
                    output devData, devOe, irqOut, irqOe);
    modport host (output addr, csN, rdDsN, wrRwN, byteLaneSelN, ale, busWidthSel,
                  hostProtocolSel, muxBusSel, hardInitN, hostData, hostOe,
                  input dataLine, irqLine);
endinterface
`default_nettype wire

// *** rtl/irq_unit.sv ***
// interrupt status, summary and pin driver
`timescale 1ns/1ns
`default_nettype none
module irq_unit #(
    parameter int GROUPS = host_bus_pkg::IRQ_GROUPS
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                initN,
    // sources and controls
    input  wire logic [GROUPS*8-1:0] events,
    input  wire logic [GROUPS*8-1:0] clear,
    input  wire logic [GROUPS*8-1:0] mask,
    input  wire logic [1:0]          pinStyle,
    // state and pin
    output logic      [GROUPS*8-1:0] status,
    output logic      [7:0]          summary,
    output logic                     irqOut,
    output logic                     irqOe
);
    logic [GROUPS*8-1:0] status_reg;
    logic                pending;
    // per-group summary of unmasked pending bits
    always_comb
    begin
        summary = 8'h00;
        for (int g = 0; g < GROUPS; g++)
            summary[g] = |(status_reg[g*8 +: 8] & ~mask[g*8 +: 8]);
    end
    assign pending = |summary;
    assign status  = status_reg;
    // sticky status, a new event beats a clear
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            status_reg <= '0;
        else if (!initN)
            status_reg <= '0;
        else
            status_reg <= (status_reg & ~clear) | events;
    end
    // pin style from the configuration byte
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqOut <= 1'b0;
            irqOe  <= 1'b0;
        end
        else
        begin
            case (pinStyle)
                host_bus_pkg::IPC_PP_LOW:  begin irqOut <= !pending; irqOe <= initN; end
                host_bus_pkg::IPC_PP_HIGH: begin irqOut <= pending;  irqOe <= initN; end
                default:                   begin irqOut <= 1'b0;     irqOe <= pending && initN; end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/host_bus_master.sv ***
// host end: apb-programmed controller that runs pin cycles
`timescale 1ns/1ns
`default_nettype none
module host_bus_master #(
    parameter int STROBE_CYCLES = host_bus_pkg::STROBE_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    host_bus_if.host         bus
);
    typedef enum logic [2:0] {H_IDLE, H_ALE, H_SETUP, H_STROBE, H_RELEASE} host_state_e;
    host_state_e state_reg;
    logic [3:0]  cfg_reg;
    logic [9:0]  addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic        isRead_reg;
    logic        isWord_reg;
    logic [7:0]  cnt_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        csN_reg;
    logic        rdDsN_reg;
    logic        wrRwN_reg;
    logic        ale_reg;
    logic [15:0] oe_reg;
    wire         apbWr;
    wire         go;
    wire         wide;
    wire         moto;
    wire         word;
    wire         hiLane;
    wire  [15:0] rdSel;
    wire  [31:0] rdMux;

    // apb decode and transfer shape
    assign apbWr  = psel && penable && pwrite && pready_reg;
    assign go     = apbWr && paddr == host_bus_pkg::CTRL_OFS && pwdata[host_bus_pkg::CTRL_GO]
                    && state_reg == H_IDLE;
    assign wide   = cfg_reg[0];
    assign moto   = cfg_reg[1];
    assign word   = wide && isWord_reg;
    assign hiLane = wide && !word && (moto ? !addr_reg[0] : addr_reg[0]);
    assign rdSel  = word ? bus.dataLine : {8'h00, hiLane ? bus.dataLine[15:8] : bus.dataLine[7:0]};
    assign rdMux  = paddr == host_bus_pkg::CTRL_OFS  ? {24'h0, cfg_reg, 4'h0} :
                    paddr == host_bus_pkg::ADDR_OFS  ? {22'h0, addr_reg} :
                    paddr == host_bus_pkg::WDATA_OFS ? {16'h0, wdata_reg} :
                    paddr == host_bus_pkg::RDATA_OFS ? {16'h0, rdata_reg} :
                    paddr == host_bus_pkg::STAT_OFS  ?
                        {30'h0, !bus.irqLine, state_reg != H_IDLE} : 32'h0;

    // zero-wait apb answer, registered in the setup cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= '0;
        end
        else
        begin
            pready_reg <= psel && !penable;
            prdata_reg <= (psel && !penable) ? rdMux : prdata_reg;
        end
    end

    // controller registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_reg    <= '0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            isRead_reg <= 1'b0;
            isWord_reg <= 1'b0;
        end
        else if (apbWr && paddr == host_bus_pkg::CTRL_OFS)
        begin
            cfg_reg <= pwdata[host_bus_pkg::CTRL_INIT:host_bus_pkg::CTRL_WIDE];
            if (go)
            begin
                isRead_reg <= pwdata[host_bus_pkg::CTRL_READ];
                isWord_reg <= pwdata[host_bus_pkg::CTRL_WORD];
            end
        end
        else if (apbWr && paddr == host_bus_pkg::ADDR_OFS && state_reg == H_IDLE)
            addr_reg <= pwdata[9:0];
        else if (apbWr && paddr == host_bus_pkg::WDATA_OFS && state_reg == H_IDLE)
            wdata_reg <= pwdata[15:0];
    end

    // pin cycle sequencer
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= H_IDLE;
            cnt_reg   <= '0;
            csN_reg   <= 1'b1;
            rdDsN_reg <= 1'b1;
            wrRwN_reg <= 1'b1;
            ale_reg   <= 1'b0;
            oe_reg    <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            case (state_reg)
                H_IDLE:
                    if (go)
                    begin
                        ale_reg   <= pwdata[host_bus_pkg::CTRL_MUX];
                        state_reg <= pwdata[host_bus_pkg::CTRL_MUX] ? H_ALE : H_SETUP;
                    end
                H_ALE:
                begin
                    ale_reg   <= 1'b0;
                    state_reg <= H_SETUP;
                end
                H_SETUP:
                begin
                    csN_reg   <= 1'b0;
                    wrRwN_reg <= moto ? isRead_reg : 1'b1;
                    oe_reg    <= isRead_reg ? 16'h0 :
                                 word ? 16'hffff : hiLane ? 16'hff00 : 16'h00ff;
                    cnt_reg   <= '0;
                    state_reg <= H_STROBE;
                end
                H_STROBE:
                begin
                    rdDsN_reg <= !(moto || isRead_reg);
                    wrRwN_reg <= moto ? isRead_reg : isRead_reg;
                    cnt_reg   <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(STROBE_CYCLES))
                    begin
                        rdDsN_reg <= 1'b1;
                        wrRwN_reg <= moto ? isRead_reg : 1'b1;
                        if (isRead_reg)
                            rdata_reg <= rdSel;
                        state_reg <= H_RELEASE;
                    end
                end
                H_RELEASE:
                begin
                    csN_reg   <= 1'b1;
                    wrRwN_reg <= 1'b1;
                    oe_reg    <= '0;
                    state_reg <= H_IDLE;
                end
                default:
                    state_reg <= H_IDLE;
            endcase
        end
    end

    // pins from flops
    assign bus.addr            = word ? {addr_reg[9:1], 1'b0} : addr_reg;
    assign bus.csN             = csN_reg;
    assign bus.rdDsN           = rdDsN_reg;
    assign bus.wrRwN           = wrRwN_reg;
    assign bus.byteLaneSelN    = !(wide && (word || addr_reg[0]));
    assign bus.ale             = ale_reg;
    assign bus.busWidthSel     = wide;
    assign bus.hostProtocolSel = moto;
    assign bus.muxBusSel       = cfg_reg[2];
    assign bus.hardInitN       = !cfg_reg[3];
    assign bus.hostData        = word ? wdata_reg : {wdata_reg[7:0], wdata_reg[7:0]};
    assign bus.hostOe          = oe_reg;
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = 1'b0;
endmodule
`default_nettype wire

// *** testbench/host_bus_assertions.sv ***
// concurrent checks on the pins between host controller and device
`timescale 1ns/1ns
`default_nettype none
module host_bus_assertions (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset_n,
    // pins
    input wire logic [9:0]  addr,
    input wire logic        csN,
    input wire logic        rdDsN,
    input wire logic        wrRwN,
    input wire logic        byteLaneSelN,
    input wire logic        busWidthSel,
    input wire logic        hostProtocolSel,
    input wire logic        hardInitN,
    input wire logic [15:0] devOe,
    input wire logic        irqOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // access qualifiers, read wins in separate mode
    wire rdOn  = !csN && !rdDsN && hardInitN && (!hostProtocolSel || wrRwN);
    wire wrSep = !csN && !wrRwN && rdDsN && !hostProtocolSel;
    wire wrDs  = !csN && !rdDsN && !wrRwN && hostProtocolSel;
    wire wide  = busWidthSel && hardInitN;
    chk_init_quiet: assert property ((!hardInitN) [*2] |-> devOe == 16'h0000 && !irqOe)
        else $error("device drives pins during init");
    chk_select_gate: assert property (csN [*2] |-> devOe == 16'h0000)
        else $error("device drives while not selected");
    chk_narrow_upper: assert property ((!busWidthSel) [*2] |-> devOe[15:8] == 8'h00)
        else $error("upper lines driven in 8-bit mode");
    chk_narrow_read: assert property (rdOn && $past(rdOn) && !busWidthSel
        |-> devOe == 16'h00ff)
        else $error("8-bit read lanes wrong");
    chk_word_read: assert property (rdOn && $past(rdOn) && wide && !addr[0]
        && !byteLaneSelN |-> devOe == 16'hffff)
        else $error("word read lanes wrong");
    chk_upper_sep: assert property (rdOn && $past(rdOn) && wide && addr[0]
        && !hostProtocolSel && !byteLaneSelN |-> devOe == 16'hff00)
        else $error("separate mode upper lane wrong");
    chk_lower_strobe: assert property (rdOn && $past(rdOn) && wide && addr[0]
        && hostProtocolSel && !byteLaneSelN |-> devOe == 16'h00ff)
        else $error("strobe mode lower lane wrong");
    chk_write_sep: assert property (wrSep && $past(wrSep) |-> devOe == 16'h0000)
        else $error("device drives during write");
    chk_write_strobe: assert property (wrDs && $past(wrDs) |-> devOe == 16'h0000)
        else $error("device drives during strobe write");
endmodule
`default_nettype wire

// *** testbench/host_bus_interface_tb.sv ***
// self-checking bench joining host controller and device port
`timescale 1ns/1ns
`default_nettype none
module host_bus_interface_tb;
    typedef struct packed {logic [7:0] ctrl; logic [9:0] a; logic wr; logic [15:0] d, m;} row_s;
    logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, writeSeen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic [47:0] irqEvents;
    logic [9:0]  writeAddr;
    int          errorCnt, checks, writeCnt, wrExp;
    row_s        rows [9];
    host_bus_if host_bus_if_i ();
    host_bus_master host_bus_master_i (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(host_bus_if_i));
    host_bus_device host_bus_device_i (.core_clk(core_clk), .reset_n(reset_n),
        .bus(host_bus_if_i), .irqEvents(irqEvents), .writeSeen(writeSeen), .writeAddr(writeAddr));
    host_bus_assertions host_bus_assertions_i (.core_clk(core_clk), .reset_n(reset_n),
        .addr(host_bus_if_i.addr), .csN(host_bus_if_i.csN), .rdDsN(host_bus_if_i.rdDsN),
        .wrRwN(host_bus_if_i.wrRwN), .byteLaneSelN(host_bus_if_i.byteLaneSelN),
        .busWidthSel(host_bus_if_i.busWidthSel), .hostProtocolSel(host_bus_if_i.hostProtocolSel),
        .hardInitN(host_bus_if_i.hardInitN), .devOe(host_bus_if_i.devOe),
        .irqOe(host_bus_if_i.irqOe));
    task automatic print_verdict();
        $display("errors %0d checks %0d", errorCnt, checks);
        if (errorCnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic give_up();
        errorCnt++;
        print_verdict();
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (++n > 20) give_up();
        end
        while (pready !== 1'b1);
        rdVal = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one pin cycle through the controller, then fetch captured data
    task automatic pin(input logic [7:0] ctrl, input logic [9:0] a, input logic [15:0] d);
        int n;
        n = 0;
        apb(1'b1, host_bus_pkg::ADDR_OFS, {22'h0, a});
        apb(1'b1, host_bus_pkg::WDATA_OFS, {16'h0, d});
        apb(1'b1, host_bus_pkg::CTRL_OFS, {24'h0, ctrl | 8'h01});
        if (ctrl[1] == 1'b0 && ctrl[7] == 1'b0) wrExp++;
        do
        begin
            apb(1'b0, host_bus_pkg::STAT_OFS, 32'h0);
            if (++n > 50) give_up();
        end
        while (rdVal[host_bus_pkg::STAT_BUSY] !== 1'b0);
        apb(1'b0, host_bus_pkg::RDATA_OFS, 32'h0);
    endtask
    task automatic irq_is(input logic exp);
        apb(1'b0, host_bus_pkg::STAT_OFS, 32'h0);
        check("irq", {15'h0, rdVal[host_bus_pkg::STAT_IRQ]}, {15'h0, exp});
    endtask
    // committed host writes
    always @(posedge core_clk)
        if (writeSeen === 1'b1) writeCnt++;
    // free-running clock, kept up through device init
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, reset_n} = '0;
        irqEvents = '0;
        {errorCnt, checks, writeCnt, wrExp} = '0;
        // mode bits: 10 wide, 04 word, 20 strobe style, 40 muxed address
        rows = '{'{8'h00, 10'h010, 1, 16'h00a5, 16'h00ff}, '{8'h20, 10'h011, 1, 16'h003c, 16'h00ff},
            '{8'h14, 10'h020, 1, 16'hbeef, 16'hffff}, '{8'h34, 10'h023, 1, 16'h1234, 16'hffff},
            '{8'h00, 10'h020, 0, 16'h00ef, 16'h00ff}, '{8'h20, 10'h023, 0, 16'h0034, 16'h00ff},
            '{8'h10, 10'h021, 0, 16'h00be, 16'hffff}, '{8'h30, 10'h021, 0, 16'h00be, 16'hffff},
            '{8'h40, 10'h012, 1, 16'h0077, 16'h00ff}};
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        pin(8'h02, host_bus_pkg::MASK_BASE, 16'h0);
        check("mask", rdVal[15:0] & 16'h00ff, {8'h0, host_bus_pkg::MASK_RESET});
        foreach (rows[i])
        begin
            if (rows[i].wr)
            begin
                pin(rows[i].ctrl, rows[i].a, rows[i].d);
                check("waddr", {6'h0, writeAddr}, {6'h0, rows[i].a});
            end
            pin(rows[i].ctrl | 8'h02, rows[i].a, 16'h0);
            check("rdata", rdVal[15:0] & rows[i].m, rows[i].d);
        end
        // interrupt raised, masked, cleared and restyled
        @(posedge core_clk);
        irqEvents <= 48'h1;
        @(posedge core_clk);
        irqEvents <= '0;
        irq_is(1'b0);
        pin(8'h00, host_bus_pkg::MASK_BASE, 16'h0);
        irq_is(1'b1);
        pin(8'h02, host_bus_pkg::GIS_ADDR, 16'h0);
        check("summary", rdVal[15:0] & 16'h00ff, 16'h0001);
        pin(8'h02, host_bus_pkg::STAT_BASE, 16'h0);
        check("status", rdVal[15:0] & 16'h00ff, 16'h0001);
        irq_is(1'b0);
        pin(8'h00, host_bus_pkg::IPC_ADDR, {14'h0, host_bus_pkg::IPC_PP_HIGH});
        irq_is(1'b1);
        pin(8'h00, host_bus_pkg::IPC_ADDR, {14'h0, host_bus_pkg::IPC_PP_LOW});
        irq_is(1'b0);
        // write during device init is dropped, init restores masks
        pin(8'h80, 10'h010, 16'h0055);
        apb(1'b1, host_bus_pkg::CTRL_OFS, 32'h0);
        pin(8'h02, 10'h010, 16'h0);
        check("held", rdVal[15:0] & 16'h00ff, 16'h00a5);
        pin(8'h02, host_bus_pkg::MASK_BASE, 16'h0);
        check("mask", rdVal[15:0] & 16'h00ff, {8'h0, host_bus_pkg::MASK_RESET});
        check("wcount", writeCnt[15:0], wrExp[15:0]);
        print_verdict();
    end
endmodule
`default_nettype wire
